// *** logic/psc_panel.sv ***
// front-panel lamp driver, switch decoder and serial config register block
// Functional notes
// - ready lamp lights only once power-up diagnostics pass
// - run lamp steady while running; also carries blink error codes
// - serial lamp lights while the serial port is active
// - network lamp lights while the network port is active
// - amber lamp lights while memory protect switch is engaged
// - red battery lamp lights when battery needs replacing
// - red error lamp lights on network communication error
// - crash blinks run lamp by error group; code 0000 blinks continuously
// - codes 80B, 80C, 82E give two blinks
// - codes 769 and 72A through 730 give three blinks
// - codes 604 through 631 give four blinks
// - codes 503, 52D and 402 give five blinks
// - codes 8001 through 8003 give three blinks
// - left switch top position alone enables memory write protection
// - right switch top fixes ASCII, 2400 baud, even, 7 data, 1 stop
// - right switch middle fixes RTU, 9600 baud, even, 8 data, 1 stop
// - right switch bottom uses software settings, address 1 to 247
// - fixed ASCII or RTU settings default to bridge mode
// - fixed modes take station address from rotary switches
// - address equals ten times tens digit plus ones digit
// - highest settable rotary address is 64
// - address 0 or above 64 holds network lamp steadily on
`include "psc_map.svh"
module psc_panel #(
  parameter int BLINK_CYC = `PSC_BLINK_CYC,
  parameter int PAUSE_CYC = `PSC_PAUSE_CYC,
  parameter int DEBOUNCE_CYC = `PSC_DEBOUNCE_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire psc_pkg::psc_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // panel switch pins
  input wire logic [1:0] protect_slide,
  input wire logic [1:0] mode_slide,
  input wire logic [3:0] address_tens_selector,
  input wire logic [3:0] address_ones_selector,
  // status from port and diagnostic logic
  input wire logic serial_activity,
  input wire logic net_activity,
  input wire logic net_comm_error,
  input wire logic battery_low,
  // decoded outputs
  output psc_pkg::psc_lamps_t lamps,
  output psc_pkg::psc_sercfg_t sercfg,
  output logic mem_protect,
  output logic [6:0] node_address,
  output logic node_address_bad
);
  import psc_pkg::*;

  // counter widths follow the timing parameters; short settings stay small
  localparam int SW_W = 12;
  localparam int DB_W = $clog2(DEBOUNCE_CYC + 1);
  localparam int BT_W = $clog2(PAUSE_CYC + BLINK_CYC + 1);

  // two-stage synchronisers for the switch pins
  logic [SW_W-1:0] sw_pin;
  logic [SW_W-1:0] sw_meta_q;
  logic [SW_W-1:0] sw_sync_q;
  logic [SW_W-1:0] sw_stable_q;
  assign sw_pin = {protect_slide, mode_slide, address_tens_selector, address_ones_selector};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_meta_q <= '0;
      sw_sync_q <= '0;
    end else begin
      sw_meta_q <= sw_pin;
      sw_sync_q <= sw_meta_q;
    end
  end

  // debounce: a bit is taken only after it has held for the full window
  // any bounce restarts the count, so a chattering contact costs settle
  // time but never shows a false position
  genvar gi;
  generate
    for (gi = 0; gi < SW_W; gi++) begin : g_db
      logic [DB_W-1:0] cnt_q;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q <= '0;
          sw_stable_q[gi] <= 1'b0;
        end else if (sw_sync_q[gi] == sw_stable_q[gi]) begin
          cnt_q <= '0;
        end else if (cnt_q == DB_W'(DEBOUNCE_CYC - 1)) begin
          cnt_q <= '0;
          sw_stable_q[gi] <= sw_sync_q[gi];
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  endgenerate

  logic [1:0] prot_sw;
  logic [1:0] mode_sw;
  logic [3:0] tens_sw;
  logic [3:0] ones_sw;
  assign {prot_sw, mode_sw, tens_sw, ones_sw} = sw_stable_q;

  // status inputs come from other clock domains too, so sync them
  // no debounce on these: activity strobes are meant to flicker the lamps,
  // and a lamp a few cycles late is harmless
  logic [3:0] st_meta_q;
  logic [3:0] st_sync_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_meta_q <= '0;
      st_sync_q <= '0;
    end else begin
      st_meta_q <= {serial_activity, net_activity, net_comm_error, battery_low};
      st_sync_q <= st_meta_q;
    end
  end

  // rotary address decode
  // ten times a legal tens digit plus a ones digit fits seven bits;
  // larger dial codes wrap but are flagged invalid below
  logic [6:0] rot_addr;
  logic rot_bad;
  assign rot_addr = 7'(tens_sw * 4'hA) + 7'(ones_sw);
  // digits above 9 are outside the dial; treat as invalid too
  assign rot_bad = (rot_addr == 7'h00) || (rot_addr > `PSC_ROT_ADDR_MAX) ||
                   (tens_sw > 4'h9) || (ones_sw > 4'h9);

  // register map, one aligned word each:
  //   0x000 control: bit 0 diagnostics passed, bit 1 running
  //   0x004 serial config: baud index, parity, data, stop, station
  //   0x008 crash: code in the low half, bit 16 arms the blinker
  //   0x00C status: lamp image, read only
  //   0x010 port config: frame settings in use, read only
  //   0x014 address: rotary address, bit 8 flags an invalid one
  // unmapped or unaligned addresses answer with an error and do nothing
  // software registers
  logic [31:0] ctrl_q;
  logic [31:0] swcfg_q;
  logic [15:0] crash_code_q;
  logic crash_valid_q;
  logic apb_wr;
  logic apb_rd;
  assign apb_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign apb_rd = apb_req.psel && apb_req.penable && !apb_req.pwrite;

  logic addr_hit;
  always_comb begin
    unique case (apb_req.paddr)
      `PSC_OFF_CTRL, `PSC_OFF_SERCFG, `PSC_OFF_CRASH,
      `PSC_OFF_STATUS, `PSC_OFF_PORTCFG, `PSC_OFF_ADDR: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // control register: diagnostics pass and running flags
  // software owns both flags; the ready lamp waits for bit 0 to be set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `PSC_CTRL_RESET;
    end else if (apb_wr && pready && apb_req.paddr == `PSC_OFF_CTRL) begin
      ctrl_q <= {30'h0, apb_req.pwdata[1:0]};
    end
  end

  // software serial config; address outside 1..247 is rejected
  // a refused write still answers without error; read back to confirm
  logic [7:0] wr_station;
  assign wr_station = apb_req.pwdata[`PSC_SC_ADDR_HI:`PSC_SC_ADDR_LO];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swcfg_q <= `PSC_SC_RESET;
    end else if (apb_wr && pready && apb_req.paddr == `PSC_OFF_SERCFG &&
                 wr_station >= `PSC_SW_ADDR_MIN && wr_station <= `PSC_SW_ADDR_MAX) begin
      swcfg_q <= {16'h0, apb_req.pwdata[15:0]};
    end
  end

  // crash code: written by diagnostics software, bit 16 arms it
  // the code is held as written; clearing bit 16 hands the lamp back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crash_code_q <= 16'h0000;
      crash_valid_q <= 1'b0;
    end else if (apb_wr && pready && apb_req.paddr == `PSC_OFF_CRASH) begin
      crash_code_q <= apb_req.pwdata[`PSC_CR_CODE_HI:0];
      crash_valid_q <= apb_req.pwdata[`PSC_CR_VALID];
    end
  end

  // crash code to blink count; 0 means continuous, 1 means unknown code
  logic [2:0] blink_num;
  always_comb begin
    blink_num = 3'd1;
    if (crash_code_q == 16'h0000) begin
      blink_num = 3'd0;
    end else if (crash_code_q == 16'h080B || crash_code_q == 16'h080C ||
                 crash_code_q == 16'h082E) begin
      blink_num = 3'd2;
    end else if (crash_code_q == 16'h0769 ||
                 (crash_code_q >= 16'h072A && crash_code_q <= 16'h0730)) begin
      blink_num = 3'd3;
    end else if (crash_code_q >= 16'h0604 && crash_code_q <= 16'h0631) begin
      blink_num = 3'd4;
    end else if (crash_code_q == 16'h0503 || crash_code_q == 16'h052D ||
                 crash_code_q == 16'h0402) begin
      blink_num = 3'd5;
    end else if (crash_code_q >= 16'h8001 && crash_code_q <= 16'h8003) begin
      blink_num = 3'd3;
    end
  end

  // blink sequencer: equal on/off pulses, then a long pause
  // the timer counts down to zero, so each phase lasts its full length;
  // a code change mid-group can stretch or cut that one group, the next
  // group is clean
  psc_blink_t bl_state_q;
  logic [BT_W-1:0] bl_timer_q;
  logic [2:0] bl_count_q;
  logic bl_lamp;
  logic bl_expire;
  assign bl_expire = (bl_timer_q == '0);
  assign bl_lamp = (bl_state_q == PSC_BL_ON);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bl_state_q <= PSC_BL_IDLE;
      bl_timer_q <= '0;
      bl_count_q <= 3'd0;
    end else if (!crash_valid_q) begin
      bl_state_q <= PSC_BL_IDLE;
      bl_timer_q <= '0;
      bl_count_q <= 3'd0;
    end else begin
      unique case (bl_state_q)
        PSC_BL_IDLE: begin
          bl_state_q <= PSC_BL_ON;
          bl_timer_q <= BT_W'(BLINK_CYC - 1);
          bl_count_q <= 3'd1;
        end
        PSC_BL_ON: begin
          if (bl_expire) begin
            bl_state_q <= PSC_BL_OFF;
            bl_timer_q <= BT_W'(BLINK_CYC - 1);
          end else begin
            bl_timer_q <= bl_timer_q - 1'b1;
          end
        end
        PSC_BL_OFF: begin
          if (!bl_expire) begin
            bl_timer_q <= bl_timer_q - 1'b1;
          end else if (blink_num == 3'd0 || bl_count_q < blink_num) begin
            // continuous mode never pauses
            bl_state_q <= PSC_BL_ON;
            bl_timer_q <= BT_W'(BLINK_CYC - 1);
            bl_count_q <= bl_count_q + 1'b1;
          end else begin
            bl_state_q <= PSC_BL_PAUSE;
            bl_timer_q <= BT_W'(PAUSE_CYC - 1);
          end
        end
        PSC_BL_PAUSE: begin
          if (bl_expire) begin
            bl_state_q <= PSC_BL_ON;
            bl_timer_q <= BT_W'(BLINK_CYC - 1);
            bl_count_q <= 3'd1;
          end else begin
            bl_timer_q <= bl_timer_q - 1'b1;
          end
        end
      endcase
    end
  end

  // serial frame selection from the right slide switch
  // fixed positions force even parity, one stop bit, bridging and the dial
  // address; software mode leaves bridging off
  psc_sercfg_t cfg_d;
  always_comb begin
    cfg_d = '0;
    unique case (mode_sw)
      `PSC_SLIDE_TOP: begin
        cfg_d.mode = PSC_MODE_ASCII;
        cfg_d.baud_sel = `PSC_BAUD_2400;
        cfg_d.parity_en = 1'b1;
        cfg_d.data8 = 1'b0;
        cfg_d.station = {1'b0, rot_addr};
        cfg_d.bridge = 1'b1;
      end
      `PSC_SLIDE_MID: begin
        cfg_d.mode = PSC_MODE_RTU;
        cfg_d.baud_sel = `PSC_BAUD_9600;
        cfg_d.parity_en = 1'b1;
        cfg_d.data8 = 1'b1;
        cfg_d.station = {1'b0, rot_addr};
        cfg_d.bridge = 1'b1;
      end
      default: begin
        // bottom, and the unused code, fall back to software settings
        cfg_d.mode = PSC_MODE_SOFT;
        cfg_d.baud_sel = swcfg_q[`PSC_SC_BAUD_HI:`PSC_SC_BAUD_LO];
        cfg_d.parity_en = swcfg_q[`PSC_SC_PAR_EN];
        cfg_d.parity_odd = swcfg_q[`PSC_SC_PAR_ODD];
        cfg_d.data8 = swcfg_q[`PSC_SC_DATA8];
        cfg_d.stop2 = swcfg_q[`PSC_SC_STOP2];
        cfg_d.station = swcfg_q[`PSC_SC_ADDR_HI:`PSC_SC_ADDR_LO];
      end
    endcase
  end

  // registered decoded outputs and lamps
  // every output leaves a flop, so lamps and settings never glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sercfg <= '0;
      mem_protect <= 1'b0;
      node_address <= 7'h00;
      node_address_bad <= 1'b1;
      lamps <= '0;
    end else begin
      sercfg <= cfg_d;
      mem_protect <= (prot_sw == `PSC_SLIDE_TOP);
      node_address <= rot_addr;
      node_address_bad <= rot_bad;
      lamps.ready <= ctrl_q[`PSC_CTRL_DIAG_OK];
      // crash blinking overrides the steady run indication
      lamps.run <= crash_valid_q ? bl_lamp : ctrl_q[`PSC_CTRL_RUNNING];
      lamps.serial_act <= st_sync_q[3];
      lamps.net_act <= st_sync_q[2] || rot_bad;
      lamps.write_prot <= (prot_sw == `PSC_SLIDE_TOP);
      lamps.bat_low <= st_sync_q[0];
      lamps.net_err <= st_sync_q[1];
    end
  end

  // apb answer: one wait state, data registered
  // an access seen with pready low raises it next cycle for one cycle;
  // writes above land on the edge after that, while pready is high and the request still stands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (apb_req.psel && apb_req.penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !addr_hit;
      prdata <= 32'h0000_0000;
      if (apb_rd) begin
        unique case (apb_req.paddr)
          `PSC_OFF_CTRL: prdata <= ctrl_q;
          `PSC_OFF_SERCFG: prdata <= swcfg_q;
          `PSC_OFF_CRASH: prdata <= {15'h0, crash_valid_q, crash_code_q};
          `PSC_OFF_STATUS: prdata <= {25'h0, lamps};
          `PSC_OFF_PORTCFG: prdata <= {12'h000, sercfg, 1'b0};
          `PSC_OFF_ADDR: prdata <= {23'h0, node_address_bad, 1'b0, node_address};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end
endmodule

// *** pkg/psc_map.svh ***
// register offsets, field positions, reset values and timing counts for panel status logic
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH
// register byte offsets
`define PSC_OFF_CTRL 12'h000
`define PSC_OFF_SERCFG 12'h004
`define PSC_OFF_CRASH 12'h008
`define PSC_OFF_STATUS 12'h00C
`define PSC_OFF_PORTCFG 12'h010
`define PSC_OFF_ADDR 12'h014
// control register fields
`define PSC_CTRL_DIAG_OK 0
`define PSC_CTRL_RUNNING 1
`define PSC_CTRL_RESET 32'h0000_0000
// software serial config fields
`define PSC_SC_BAUD_LO 0
`define PSC_SC_BAUD_HI 3
`define PSC_SC_PAR_EN 4
`define PSC_SC_PAR_ODD 5
`define PSC_SC_DATA8 6
`define PSC_SC_STOP2 7
`define PSC_SC_ADDR_LO 8
`define PSC_SC_ADDR_HI 15
`define PSC_SC_RESET 32'h0000_0101
// baud index encoding, 19200 down to 50
`define PSC_BAUD_19200 4'h0
`define PSC_BAUD_9600 4'h1
`define PSC_BAUD_2400 4'h5
`define PSC_BAUD_50 4'hF
// crash register fields
`define PSC_CR_CODE_HI 15
`define PSC_CR_VALID 16
// station address limits
`define PSC_SW_ADDR_MIN 8'h01
`define PSC_SW_ADDR_MAX 8'hF7
`define PSC_ROT_ADDR_MAX 7'h40
// slide switch encodings
`define PSC_SLIDE_TOP 2'h0
`define PSC_SLIDE_MID 2'h1
`define PSC_SLIDE_BOT 2'h2
// blink and debounce timing
`define PSC_BLINK_MS 250
`define PSC_PAUSE_MS 1000
`define PSC_DEBOUNCE_MS 10
`define PSC_CLK_MHZ 250
`define PSC_BLINK_CYC (`PSC_BLINK_MS * 1000 * `PSC_CLK_MHZ)
`define PSC_PAUSE_CYC (`PSC_PAUSE_MS * 1000 * `PSC_CLK_MHZ)
`define PSC_DEBOUNCE_CYC (`PSC_DEBOUNCE_MS * 1000 * `PSC_CLK_MHZ)
`endif

// *** pkg/psc_pkg.sv ***
// types shared by the panel status and configuration logic
package psc_pkg;
  typedef enum logic [1:0] {
    PSC_MODE_ASCII = 2'b00,
    PSC_MODE_RTU = 2'b01,
    PSC_MODE_SOFT = 2'b10
  } psc_mode_t;

  typedef enum logic [1:0] {
    PSC_BL_IDLE = 2'b00,
    PSC_BL_ON = 2'b01,
    PSC_BL_OFF = 2'b10,
    PSC_BL_PAUSE = 2'b11
  } psc_blink_t;

  // serial frame settings handed to the serial port
  typedef struct packed {
    psc_mode_t mode;
    logic [3:0] baud_sel;
    logic parity_en;
    logic parity_odd;
    logic data8;
    logic stop2;
    logic [7:0] station;
    logic bridge;
  } psc_sercfg_t;

  // lamp outputs
  typedef struct packed {
    logic ready;
    logic run;
    logic serial_act;
    logic net_act;
    logic write_prot;
    logic bat_low;
    logic net_err;
  } psc_lamps_t;

  // apb request from master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } psc_apb_req_t;
endpackage

// *** test/psc_panel_properties.sv ***
// port-level assertion checker for the panel status block
module psc_panel_properties
  import psc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register bus
  input wire psc_pkg::psc_apb_req_t apb_req,
  input wire logic pready,
  input wire logic pslverr,
  // decoded outputs
  input wire psc_pkg::psc_lamps_t lamps,
  input wire psc_pkg::psc_sercfg_t sercfg,
  input wire logic mem_protect,
  input wire logic [6:0] node_address,
  input wire logic node_address_bad
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // first access cycle, not yet answered
  sequence s_access;
    apb_req.psel && apb_req.penable && !pready;
  endsequence
  // held three samples so the lamp register has caught up
  sequence s_bad_held;
    node_address_bad [*3];
  endsequence

  property p_answer;
    s_access |=> pready;
  endproperty
  property p_pulse;
    pready |=> !pready;
  endproperty
  property p_err;
    pslverr |-> pready;
  endproperty
  property p_net_bad;
    s_bad_held |-> lamps.net_act;
  endproperty
  property p_addr_ok;
    !node_address_bad |-> node_address inside {[7'h01:7'h40]};
  endproperty
  property p_protect;
    mem_protect [*3] |-> lamps.write_prot;
  endproperty
  // bridge only set in fixed modes, so reset zeros do not trip this
  property p_ascii;
    sercfg.mode == PSC_MODE_ASCII && sercfg.bridge |->
      {sercfg.baud_sel, sercfg.parity_en, sercfg.parity_odd, sercfg.data8, sercfg.stop2} == 8'h58;
  endproperty
  property p_rtu;
    sercfg.mode == PSC_MODE_RTU |-> sercfg.bridge && sercfg.baud_sel == 4'h1 &&
      {sercfg.parity_en, sercfg.parity_odd, sercfg.data8, sercfg.stop2} == 4'hA;
  endproperty
  property p_soft;
    sercfg.mode == PSC_MODE_SOFT |-> !sercfg.bridge && sercfg.station inside {[8'h01:8'hF7]};
  endproperty
  property p_station;
    (sercfg.bridge && $stable(node_address)) [*3] |-> sercfg.station == {1'b0, node_address};
  endproperty

  a_answer: assert property (p_answer) else $error("access not answered next cycle");
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  a_err: assert property (p_err) else $error("pslverr without pready");
  a_net_bad: assert property (p_net_bad) else $error("bad address lamp off");
  a_addr_ok: assert property (p_addr_ok) else $error("address out of range");
  a_protect: assert property (p_protect) else $error("protect lamp off");
  a_ascii: assert property (p_ascii) else $error("ascii frame wrong");
  a_rtu: assert property (p_rtu) else $error("rtu frame wrong");
  a_soft: assert property (p_soft) else $error("software frame wrong");
  a_station: assert property (p_station) else $error("station not rotary");
endmodule

bind psc_panel psc_panel_properties psc_panel_properties_i (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .pready(pready), .pslverr(pslverr),
  .lamps(lamps), .sercfg(sercfg), .mem_protect(mem_protect), .node_address(node_address),
  .node_address_bad(node_address_bad));

// *** test/psc_switch_model.sv ***
// behavioural panel switches whose contacts chatter after each move
module psc_switch_model (
  // clock
  input wire logic pclk,
  // wanted positions: protect, mode, tens, ones
  input wire logic [11:0] target,
  // switch pins
  output logic [11:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] last_q;
  logic [2:0] cnt_q = 3'h0;
  // restart chatter on every move so debounce is really exercised
  always_ff @(posedge pclk) begin
    if (target !== last_q) begin
      last_q <= target;
      cnt_q <= 3'h4;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end
  assign pins = cnt_q[0] ? ~target : target; // inverse level on odd counts while bouncing
endmodule

// *** test/psc_panel_tb.sv ***
// self-checking bench for the panel status block
module psc_panel_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import psc_pkg::*;
  localparam int BC = 4;
  localparam int PC = 16;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  psc_apb_req_t req = '0;
  logic [3:0] stat = '0;
  logic [11:0] target = '0;
  logic [11:0] pins;
  logic [31:0] prdata, rd;
  logic pready, pslverr, mem_protect, bad, err;
  psc_lamps_t lamps;
  psc_sercfg_t sercfg;
  logic [6:0] node_address;
  int seed = 11;
  int n_mismatch = 0;
  int check_count = 0;
  logic [7:0] corner [8] = '{8'h00, 8'h64, 8'h65, 8'h01, 8'h99, 8'h0A, 8'h70, 8'h11};
  logic [15:0] code [15] = '{16'h0000, 16'h080B, 16'h080C, 16'h082E, 16'h0769, 16'h072A,
    16'h0730, 16'h0604, 16'h0631, 16'h0503, 16'h052D, 16'h0402, 16'h8001, 16'h8003, 16'h0100};

  psc_switch_model psc_switch_model_i (.pclk(pclk), .target(target), .pins(pins));
  psc_panel #(.BLINK_CYC(BC), .PAUSE_CYC(PC), .DEBOUNCE_CYC(3)) psc_panel_i (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .protect_slide(pins[11:10]), .mode_slide(pins[9:8]),
    .address_tens_selector(pins[7:4]), .address_ones_selector(pins[3:0]),
    .serial_activity(stat[3]), .net_activity(stat[2]), .net_comm_error(stat[1]),
    .battery_low(stat[0]), .lamps(lamps), .sercfg(sercfg), .mem_protect(mem_protect),
    .node_address(node_address), .node_address_bad(bad));

  // 250 MHz clock
  initial begin
    forever #2 pclk = ~pclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req <= '0;
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e, input logic se);
    apb(1'b0, a, '0);
    chk(nm, rd, e);
    chk(nm, err, se);
  endtask

  function automatic int blinks(input logic [15:0] c);
    case (c) inside
      16'h0000: return 0;
      16'h080B, 16'h080C, 16'h082E: return 2;
      16'h0769, [16'h072A:16'h0730], [16'h8001:16'h8003]: return 3;
      [16'h0604:16'h0631]: return 4;
      16'h0503, 16'h052D, 16'h0402: return 5;
      default: return 1;
    endcase
  endfunction

  function automatic psc_sercfg_t fixed_cfg(input logic [1:0] m, input logic [6:0] a);
    if (m == 2'h0) return {PSC_MODE_ASCII, 4'h5, 4'h8, 1'b0, a, 1'b1};
    return {PSC_MODE_RTU, 4'h1, 4'hA, 1'b0, a, 1'b1};
  endfunction

  // any window of one full period holds exactly one group of rises
  task automatic blink_check(input logic [15:0] c);
    int n, w, rises;
    logic prev;
    n = blinks(c);
    w = (n == 0) ? 10 * BC : 2 * BC * n + PC;
    rises = 0;
    apb(1'b1, 12'h008, {15'h0000, 1'b1, c});
    cyc(w + 4);
    prev = lamps.run;
    repeat (w) begin
      @(posedge pclk);
      if (lamps.run === 1'b1 && prev === 1'b0) rises++;
      prev = lamps.run;
    end
    chk("blinks", rises, (n == 0) ? 5 : n);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog, well beyond the few thousand cycles the tests need
  initial begin
    cyc(40000);
    n_mismatch++;
    summarize();
  end

  initial begin
    logic [6:0] a;
    logic [31:0] v;
    logic [3:0] t, o;
    logic e;
    cyc(20);
    presetn <= 1'b1;
    rchk("ctrl", 12'h000, 32'h0000_0000, 1'b0);
    rchk("sercfg", 12'h004, 32'h0000_0101, 1'b0);
    rchk("unmapped", 12'h018, 32'h0000_0000, 1'b1);
    chk("ready off", lamps.ready, 1'b0);
    $display("test registers done");
    for (int p = 0; p < 3; p++) begin
      target[11:10] <= p[1:0];
      cyc(20);
      chk("protect", mem_protect, p == 0);
      chk("protect lamp", lamps.write_prot, p == 0);
    end
    foreach (corner[i]) begin
      {t, o} = corner[i];
      target[7:0] <= corner[i];
      cyc(20);
      a = 7'(10 * t + o);
      e = a == 0 || a > 64 || t > 9 || o > 9;
      chk("bad", bad, e);
      chk("net lamp", lamps.net_act, e);
      rchk("addr reg", 12'h014, {23'h0, e, 1'b0, a}, 1'b0);
      if (o < 10) chk("addr", node_address, a);
    end
    for (int m = 0; m < 2; m++) begin
      a = 7'(1 + {$random(seed)} % 64);
      target[9:0] <= {m[1:0], 4'(a / 10), 4'(a % 10)};
      cyc(20);
      chk("fixed cfg", sercfg, fixed_cfg(m[1:0], a));
      rchk("portcfg", 12'h010, {12'h000, fixed_cfg(m[1:0], a), 1'b0}, 1'b0);
    end
    repeat (4) begin
      v = {16'h0000, 8'(1 + {$random(seed)} % 247), 8'($random(seed))};
      target[9:8] <= {1'b1, v[0]}; // bottom, or the unused code 3
      apb(1'b1, 12'h004, v);
      apb(1'b1, 12'h004, {v[31:16], 8'h00, v[7:0]});
      apb(1'b1, 12'h004, {v[31:16], 8'hF8, v[7:0]});
      cyc(20);
      chk("soft cfg", sercfg,
          {PSC_MODE_SOFT, v[3:0], v[4], v[5], v[6], v[7], v[15:8], 1'b0});
    end
    $display("test switches done");
    apb(1'b1, 12'h000, 32'h0000_0001);
    cyc(3);
    chk("ready", lamps.ready, 1'b1);
    chk("run", lamps.run, 1'b0);
    apb(1'b1, 12'h000, 32'h0000_0003);
    cyc(3);
    chk("run", lamps.run, 1'b1);
    repeat (8) begin
      stat <= 4'($random(seed));
      cyc(6);
      chk("serial lamp", lamps.serial_act, stat[3]);
      chk("network lamp", lamps.net_act, stat[2]);
      chk("error lamp", lamps.net_err, stat[1]);
      chk("battery lamp", lamps.bat_low, stat[0]);
    end
    stat <= '0;
    $display("test lamps done");
    foreach (code[i]) blink_check(code[i]);
    apb(1'b1, 12'h008, 32'h0000_0000);
    cyc(3);
    chk("run back", lamps.run, 1'b1);
    $display("test blink done");
    summarize();
  end
endmodule
